/* File: fabric_port_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Fabric loop port model
// ----------------------------------------
module fabric_port_model #(
	parameter int ED = 40,
	parameter int RA = 30
) (
	// Clock and reset
	input  wire logic   clk,
	input  wire logic   sys_rst,
	// Scenario control
	input  wire logic   okCfg,
	input  wire logic   chgCfg,
	input  wire logic   slow,
	// Requests from the port
	input  wire logic   flogiReq,
	input  wire logic   nsReq,
	// Replies
	output logic        flogiAck,
	output logic        flogiOk,
	output logic        flogiAddrChanged,
	output logic [31:0] accEdTov,
	output logic [31:0] accRaTov,
	output logic        nsAck
);
	logic [3:0] fc;
	logic [3:0] nc;
	wire  [3:0] lat = slow ? 4'h9 : 4'h1;
	// Fields hold garbage outside the ack so stale values are not trusted
	assign flogiOk          = flogiAck ? okCfg : ~okCfg;
	assign flogiAddrChanged = flogiAck ? chgCfg : ~chgCfg;
	assign accEdTov         = flogiAck ? 32'(ED) : ~32'(ED);
	assign accRaTov         = flogiAck ? 32'(RA) : ~32'(RA);
	// Answer each request after a prompt or a slow delay
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fc <= 4'h0;
			nc <= 4'h0;
			flogiAck <= 1'b0;
			nsAck <= 1'b0;
		end else begin
			fc <= flogiReq ? lat : (fc != 4'h0 ? fc - 4'h1 : 4'h0);
			nc <= nsReq ? lat : (nc != 4'h0 ? nc - 4'h1 : 4'h0);
			flogiAck <= fc == 4'h1;
			nsAck <= nc == 4'h1;
		end
	end
endmodule

/* File: loop_port_defs.svh */
`ifndef LOOP_PORT_DEFS_SVH
`define LOOP_PORT_DEFS_SVH

// Loop and fabric addresses
`define FABRIC_ALPA      8'h00
`define FLOGI_DID        24'hfffffe
`define DIRSRV_DID       24'hfffffc

// Link service reason for busy rejects (unable to perform now)
`define RJT_REASON_BUSY  8'h09

// Reset values
`define TOV_RESET        32'h0000_0000
`define ALPA_RESET       8'h00

`endif

/* File: loop_port_pkg.sv */
package loop_port_pkg;

	// Sequencer states
	typedef enum logic [3:0] {
		S_IDLE,
		S_LIP,
		S_DECIDE,
		S_FLOGI,
		S_FLOGI_WAIT,
		S_ADDR_CHG,
		S_RECOVER,
		S_FAN_WAIT,
		S_RESUME,
		S_NS_LOGIN,
		S_NS_WAIT,
		S_DONE,
		S_PRIVATE
	} seq_state_e;

	// Received frame classes
	typedef enum logic [2:0] {
		F_OTHER,
		F_FAN,
		F_ADISC,
		F_PLOGI,
		F_LOGO_ACC
	} frame_kind_e;

	// Actions requested of the frame engine
	typedef enum logic [1:0] {
		A_PASS,
		A_DISCARD,
		A_REJECT,
		A_SEND_LOGO
	} frame_act_e;

endpackage

/* File: public_loop_port_init.sv */
// How it works
// - Fabric login is sent to loop address 00h, destination fffffe.
// - Frames from the fabric port with differing source IDs are all accepted.
// - Remote-port traffic opens loop address 00h.
// - Timeouts come from the fabric login accept reply.
// - Reclaim fabric-assigned address in LIFA if previously addressed and logged in.
// - Redo fabric login on L bit, lost address, no address or no login.
// - During login open 00h full duplex, ignore FAN, reject ADISC/PLOGI busy.
// - Login failure goes private; unchanged clear L resumes; else register.
// - Address change drops exchanges, logs out all ports, enters recovery.
// - Recovery waits resource timeout, keeps only PLOGI, ADISC, LOGO accept.
// - Recovery rejects PLOGI busy and answers ADISC with a LOGO request.
// - No login needed: wait error timeout for FAN, reject ADISC/PLOGI meanwhile.
// - FAN match of address and names resumes, otherwise relogin.
// - FAN timeout leads to fabric login.
// - Unchanged address resumes exchanges; private devices need authentication.
// - Log in to directory at fffffc, try RFC-4, finish regardless.
// - No fabric port on loop means private-loop completion.
// - LIFA bit set only if logged in to the fabric before LIP.
`timescale 1ns/10ps
`include "loop_port_defs.svh"

module public_loop_port_init
	import loop_port_pkg::*;
#(
	parameter int TOV_W   = 32,
	parameter int TICK_DIV = 50
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// Loop initialization results
	input  wire logic              lipStart,
	input  wire logic              lipDone,
	input  wire logic              lispLBit,
	input  wire logic              alpaAcquired,
	input  wire logic [7:0]        alpaNow,
	input  wire logic              flPortPresent,
	// Fabric login handshake
	output logic                   flogiReq,
	output logic [23:0]            reqDestId,
	output logic [7:0]             openAlpa,
	output logic                   openFullDuplex,
	input  wire logic              flogiAck,
	input  wire logic              flogiOk,
	input  wire logic              flogiAddrChanged,
	input  wire logic [TOV_W-1:0]  accEdTov,
	input  wire logic [TOV_W-1:0]  accRaTov,
	// Directory registration handshake
	output logic                   nsReq,
	input  wire logic              nsAck,
	// Received frames
	input  wire logic              rxValid,
	input  wire frame_kind_e       rxKind,
	input  wire logic              fanMatch,
	output logic                   rxAccept,
	output frame_act_e             rxAction,
	output logic [7:0]             rjtReason,
	// Session control
	output logic                   claimFabricAlpa,
	output logic                   dropExchanges,
	output logic                   implicitLogoAll,
	output logic                   fabricLogout,
	output logic                   resumeExchanges,
	output logic                   privateAuthNeeded,
	output logic                   initDone,
	output logic                   privateMode
);

	initial begin
		if (TOV_W < 8) $error("TOV_W too small");
		if (TICK_DIV < 1) $error("TICK_DIV must be positive");
		if (TICK_DIV > 65536) $error("TICK_DIV exceeds divider width");
	end

	// ----------------------------------------------------------------
	// State and held login context
	// ----------------------------------------------------------------
	seq_state_e       state;
	seq_state_e       next_state;
	logic             hadAlpa;
	logic             loggedIn;
	logic [7:0]       prevAlpa;
	logic             firstLogin;
	logic [TOV_W-1:0] edTov;
	logic [TOV_W-1:0] raTov;

	// ----------------------------------------------------------------
	// Millisecond tick divider
	// ----------------------------------------------------------------
	logic [15:0] divCount;
	logic        tick;

	assign tick = (divCount == 16'(TICK_DIV - 1));

	// Free-running divider; timeouts are counted in its ticks
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			divCount <= 16'h0000;
		end else if (tick) begin
			divCount <= 16'h0000;
		end else begin
			divCount <= divCount + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Timeout counter
	// ----------------------------------------------------------------
	logic             tLoad;
	logic [TOV_W-1:0] tValue;
	logic             tExpired;

	// Entering recovery loads the resource timeout, FAN wait the error one
	assign tLoad  = (next_state != state) &&
			((next_state == S_RECOVER) || (next_state == S_FAN_WAIT));
	assign tValue = (next_state == S_RECOVER) ? raTov : edTov;

	tov_timer #(.WIDTH(TOV_W)) u_timer (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.load      (tLoad),
		.loadValue (tValue),
		.tick      (tick),
		.expired   (tExpired),
		.running   ()
	);

	// ----------------------------------------------------------------
	// Loop initialization results
	// ----------------------------------------------------------------
	// The loop logic may move on once lipDone has passed, so the levels
	// seen with it are kept for the decisions after the login reply
	logic       lBitHeld;
	logic       acqHeld;
	logic [7:0] alpaHeld;
	logic       lBitSeen;
	logic       acqSeen;
	logic [7:0] alpaSeen;

	assign lBitSeen = (state == S_LIP) ? lispLBit : lBitHeld;
	assign acqSeen  = (state == S_LIP) ? alpaAcquired : acqHeld;
	assign alpaSeen = (state == S_LIP) ? alpaNow : alpaHeld;

	// Captured on the edge that ends the initialization
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lBitHeld <= 1'b0;
			acqHeld  <= 1'b0;
			alpaHeld <= `ALPA_RESET;
		end else if (state == S_LIP && lipDone) begin
			lBitHeld <= lispLBit;
			acqHeld  <= alpaAcquired;
			alpaHeld <= alpaNow;
		end
	end

	// ----------------------------------------------------------------
	// Decisions
	// ----------------------------------------------------------------
	logic addrKept;
	logic needFlogi;

	assign addrKept  = hadAlpa && acqSeen && (alpaSeen == prevAlpa);
	// Any of these forces a fresh login
	assign needFlogi = lBitSeen || !addrKept || !hadAlpa || !loggedIn;

	// Address reclaim during LIFA only with prior address and login
	assign claimFabricAlpa = (state == S_LIP) && hadAlpa && loggedIn;

	// ----------------------------------------------------------------
	// Sequencer next state
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			S_IDLE: begin
				if (lipStart) next_state = S_LIP;
			end
			S_LIP: begin
				if (lipDone) begin
					if (!flPortPresent)
						next_state = S_PRIVATE;
					else if (needFlogi)
						next_state = S_FLOGI;
					else
						next_state = S_FAN_WAIT;
				end
			end
			S_DECIDE: next_state = S_FLOGI;
			S_FLOGI: next_state = S_FLOGI_WAIT;
			S_FLOGI_WAIT: begin
				if (flogiAck) begin
					if (!flogiOk)
						next_state = S_PRIVATE;
					else if (flogiAddrChanged || !addrKept || firstLogin)
						next_state = S_ADDR_CHG;
					else if (!lBitSeen)
						next_state = S_RESUME;
					else
						next_state = S_NS_LOGIN;
				end
			end
			S_ADDR_CHG: next_state = S_RECOVER;
			S_RECOVER: begin
				if (tExpired) next_state = S_NS_LOGIN;
			end
			S_FAN_WAIT: begin
				if (rxValid && rxKind == F_FAN)
					next_state = fanMatch ? S_RESUME : S_FLOGI;
				else if (tExpired)
					next_state = S_FLOGI;
			end
			S_RESUME: next_state = S_DONE;
			S_NS_LOGIN: next_state = S_NS_WAIT;
			S_NS_WAIT: begin
				if (nsAck) next_state = S_DONE;
			end
			S_DONE, S_PRIVATE: begin
				if (lipStart) next_state = S_LIP;
			end
			default: next_state = S_IDLE;
		endcase
	end

	// A new LIP always restarts the sequence
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= S_IDLE;
		end else if (lipStart) begin
			state <= S_LIP;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Login context
	// ----------------------------------------------------------------
	logic flogiPass;

	assign flogiPass = (state == S_FLOGI_WAIT) && flogiAck && flogiOk;

	// Timeouts captured from the login accept, address from the held loop results
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			edTov      <= `TOV_RESET;
			raTov      <= `TOV_RESET;
			loggedIn   <= 1'b0;
			hadAlpa    <= 1'b0;
			prevAlpa   <= `ALPA_RESET;
			firstLogin <= 1'b1;
		end else if (flogiPass) begin
			edTov      <= accEdTov;
			raTov      <= accRaTov;
			loggedIn   <= 1'b1;
			hadAlpa    <= 1'b1;
			prevAlpa   <= alpaSeen;
			firstLogin <= 1'b0;
		end else if (fabricLogout) begin
			loggedIn   <= 1'b0;
			// No completed login before this LIP means addressing is new
			if (state == S_LIP)
				firstLogin <= !loggedIn;
		end else if (state == S_PRIVATE) begin
			hadAlpa    <= acqSeen;
			prevAlpa   <= alpaSeen;
		end
	end

	// ----------------------------------------------------------------
	// Link requests
	// ----------------------------------------------------------------
	// Fabric login goes out via loop address 00h in full duplex
	assign flogiReq       = (state == S_FLOGI);
	assign nsReq          = (state == S_NS_LOGIN);
	assign openFullDuplex = (state == S_FLOGI) || (state == S_FLOGI_WAIT);
	assign openAlpa       = `FABRIC_ALPA;

	// Destination register follows the pending request
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reqDestId <= `FLOGI_DID;
		end else if (next_state == S_FLOGI) begin
			reqDestId <= `FLOGI_DID;
		end else if (next_state == S_NS_LOGIN) begin
			reqDestId <= `DIRSRV_DID;
		end
	end

	// ----------------------------------------------------------------
	// Session control pulses and completion levels
	// ----------------------------------------------------------------
	assign dropExchanges   = (state == S_ADDR_CHG);
	assign implicitLogoAll = (state == S_ADDR_CHG);
	// Logging out of fabric before a relogin chosen at LIP end or on a FAN mismatch, not on FAN timeout
	assign fabricLogout    = (state == S_LIP && lipDone && flPortPresent &&
				  needFlogi) ||
				 (state == S_FAN_WAIT && rxValid &&
				  rxKind == F_FAN && !fanMatch);
	assign resumeExchanges   = (state == S_RESUME);
	assign privateAuthNeeded = (state == S_RESUME);
	assign initDone          = (state == S_DONE);
	assign privateMode       = (state == S_PRIVATE);

	// ----------------------------------------------------------------
	// Frame filter
	// ----------------------------------------------------------------
	logic isReqLs;
	logic inFlogi;

	assign isReqLs = (rxKind == F_ADISC) || (rxKind == F_PLOGI);
	assign inFlogi = (state == S_FLOGI) || (state == S_FLOGI_WAIT);

	// Multiple source IDs in one tenancy are never filtered here
	always_comb begin
		rxAction = A_PASS;
		if (inFlogi) begin
			if (isReqLs)
				rxAction = A_REJECT;
			else if (rxKind == F_FAN)
				rxAction = A_DISCARD;
		end else if (state == S_RECOVER) begin
			if (rxKind == F_PLOGI)
				rxAction = A_REJECT;
			else if (rxKind == F_ADISC)
				rxAction = A_SEND_LOGO;
			else if (rxKind != F_LOGO_ACC)
				rxAction = A_DISCARD;
		end else if (state == S_FAN_WAIT) begin
			if (isReqLs)
				rxAction = A_REJECT;
			else if (rxKind != F_FAN)
				rxAction = A_DISCARD;
		end
	end

	assign rxAccept  = rxValid && (rxAction == A_PASS);
	assign rjtReason = `RJT_REASON_BUSY;

endmodule

/* File: public_loop_port_init_chk.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Port sequencer checker
// ----------------------------------------
module public_loop_port_init_chk
	import loop_port_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        sys_rst,
	// Loop results
	input wire logic        lipDone,
	input wire logic        lispLBit,
	input wire logic        flPortPresent,
	// Requests
	input wire logic        flogiReq,
	input wire logic        nsReq,
	input wire logic [23:0] reqDestId,
	input wire logic [7:0]  openAlpa,
	input wire logic        openFullDuplex,
	// Frames
	input wire logic        rxValid,
	input wire frame_kind_e rxKind,
	input wire logic        rxAccept,
	input wire frame_act_e  rxAction,
	input wire logic [7:0]  rjtReason,
	// Session
	input wire logic        dropExchanges,
	input wire logic        implicitLogoAll,
	input wire logic        resumeExchanges,
	input wire logic        initDone,
	input wire logic        privateMode
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Frames seen while login is open
	wire logic loginRx = openFullDuplex && rxValid;
	wire logic reqRx   = rxKind == F_ADISC || rxKind == F_PLOGI;

	a_login_dest: assert property (
		flogiReq |-> reqDestId == 24'hfffffe && openAlpa == 8'h00)
		else $error("login sent to wrong address");
	a_ns_dest: assert property (
		nsReq |-> reqDestId == 24'hfffffc && openAlpa == 8'h00)
		else $error("directory request to wrong address");
	a_login_duplex: assert property (flogiReq |-> openFullDuplex)
		else $error("login not opened full duplex");
	a_busy_reject: assert property (
		loginRx && reqRx |-> rxAction == A_REJECT && rjtReason == 8'h09)
		else $error("request during login not rejected busy");
	a_fan_ignore: assert property (
		loginRx && rxKind == F_FAN |-> !rxAccept)
		else $error("announcement accepted during login");
	a_lbit_login: assert property (
		lipDone && lispLBit && flPortPresent |=> flogiReq)
		else $error("no login after set L bit");
	a_private_path: assert property (
		lipDone && !flPortPresent |-> ##[1:4] privateMode)
		else $error("no private completion without fabric port");
	a_drop_logo: assert property (
		dropExchanges |-> implicitLogoAll ##1 !dropExchanges)
		else $error("exchanges dropped without logout");
	a_recover_wait: assert property (dropExchanges |-> ##[30:36] nsReq)
		else $error("recovery wait length wrong");
	a_resume_done: assert property (
		resumeExchanges |-> ##[1:2] initDone)
		else $error("resume not followed by completion");

	c_done: cover property ($rose(initDone));
	c_priv: cover property ($rose(privateMode));
	c_drop: cover property (dropExchanges);
	c_res:  cover property (resumeExchanges);
endmodule

/* File: testbench.sv */
`timescale 1ns/10ps
bind public_loop_port_init public_loop_port_init_chk chk (
	.clk(clk), .sys_rst(sys_rst), .lipDone(lipDone), .lispLBit(lispLBit),
	.flPortPresent(flPortPresent), .flogiReq(flogiReq), .nsReq(nsReq),
	.reqDestId(reqDestId), .openAlpa(openAlpa),
	.openFullDuplex(openFullDuplex), .rxValid(rxValid), .rxKind(rxKind),
	.rxAccept(rxAccept), .rxAction(rxAction), .rjtReason(rjtReason),
	.dropExchanges(dropExchanges), .implicitLogoAll(implicitLogoAll),
	.resumeExchanges(resumeExchanges), .initDone(initDone),
	.privateMode(privateMode));
// ----------------------------------------
// Sequencer testbench
// ----------------------------------------
module testbench
	import loop_port_pkg::*;
	;
	typedef struct packed {
		logic lb, acq, fp, ok, chg;
		logic [1:0] fan;
		logic clm, eLogin, eDrop, eNs, eRes, ePriv;
	} row_s;
	logic        clk, sys_rst, lipStart, lipDone, lispLBit, alpaAcquired;
	logic        flPortPresent, flogiReq, openFullDuplex, flogiAck, flogiOk;
	logic        flogiAddrChanged, nsReq, nsAck, rxValid, fanMatch, rxAccept;
	logic        claimFabricAlpa, dropExchanges, implicitLogoAll;
	logic        resumeExchanges, initDone, privateMode, okCfg, chgCfg, slow;
	logic        fabricLogout, privateAuthNeeded;
	logic [23:0] reqDestId;
	logic [7:0]  openAlpa, rjtReason, alpaNow;
	logic [31:0] accEdTov, accRaTov;
	frame_kind_e rxKind;
	frame_act_e  rxAction;
	int          error_cnt, comparisons, nF, nD, nN, nR, nL, nA;
	// Fan: 0 login at once, 1 matching, 2 mismatching, 3 none sent
	row_s rows[8] = '{
		'{0,1,1,1,0,0, 0,1,1,1,0,0}, '{0,1,1,1,0,1, 1,0,0,0,1,0},
		'{1,1,1,1,0,0, 1,1,0,1,0,0}, '{0,1,1,1,0,3, 1,1,0,0,1,0},
		'{0,1,1,1,1,2, 1,1,1,1,0,0}, '{0,0,1,1,1,0, 1,1,1,1,0,0},
		'{1,1,1,0,0,0, 1,1,0,0,0,1}, '{0,1,0,1,0,0, 0,0,0,0,0,1}};
	// Logged in before, but the loop hands out a different address
	row_s addrMoved = '{0,1,1,1,0,0, 1,1,1,1,0,0};

	public_loop_port_init #(.TOV_W(32), .TICK_DIV(1)) DUT (
		.clk(clk), .sys_rst(sys_rst), .lipStart(lipStart), .lipDone(lipDone),
		.lispLBit(lispLBit), .alpaAcquired(alpaAcquired), .alpaNow(alpaNow),
		.flPortPresent(flPortPresent), .flogiReq(flogiReq),
		.reqDestId(reqDestId), .openAlpa(openAlpa),
		.openFullDuplex(openFullDuplex), .flogiAck(flogiAck),
		.flogiOk(flogiOk), .flogiAddrChanged(flogiAddrChanged),
		.accEdTov(accEdTov), .accRaTov(accRaTov), .nsReq(nsReq),
		.nsAck(nsAck), .rxValid(rxValid), .rxKind(rxKind),
		.fanMatch(fanMatch), .rxAccept(rxAccept), .rxAction(rxAction),
		.rjtReason(rjtReason), .claimFabricAlpa(claimFabricAlpa),
		.dropExchanges(dropExchanges), .implicitLogoAll(implicitLogoAll),
		.fabricLogout(fabricLogout), .resumeExchanges(resumeExchanges),
		.privateAuthNeeded(privateAuthNeeded), .initDone(initDone),
		.privateMode(privateMode));

	fabric_port_model #(.ED(40), .RA(30)) fabric (
		.clk(clk), .sys_rst(sys_rst), .okCfg(okCfg), .chgCfg(chgCfg),
		.slow(slow), .flogiReq(flogiReq), .nsReq(nsReq),
		.flogiAck(flogiAck), .flogiOk(flogiOk),
		.flogiAddrChanged(flogiAddrChanged), .accEdTov(accEdTov),
		.accRaTov(accRaTov), .nsAck(nsAck));

	// Clock and pulse counters; counts are cleared by each row
	always #10 clk = ~clk;
	always @(posedge clk) begin
		nF += int'(flogiReq === 1'b1);
		nD += int'(dropExchanges === 1'b1);
		nN += int'(nsReq === 1'b1);
		nR += int'(resumeExchanges === 1'b1);
		nL += int'(fabricLogout === 1'b1);
		nA += int'(privateAuthNeeded === 1'b1);
	end

	task automatic tick;
		@(posedge clk) #2;
	endtask

	task automatic check(input string name, input logic [23:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One frame for one cycle; the answer is combinational. The caller
	// lowers rxValid after a group so it is never set twice in a step
	task automatic probe(input frame_kind_e k, input frame_act_e a);
		rxValid = 1'b1;
		rxKind = k;
		#1;
		check("rxAction", rxAction, a);
		check("rxAccept", rxAccept, a == A_PASS);
		tick;
	endtask

	task automatic run_row(input row_s r);
		int i;
		{nF, nD, nN, nR, nL, nA} = '0;
		okCfg = r.ok;
		chgCfg = r.chg;
		slow = r.fan == 2'h0;
		lipStart = 1'b1;
		tick;
		lipStart = 1'b0;
		check("claimFabricAlpa", claimFabricAlpa, r.clm);
		{lispLBit, alpaAcquired, flPortPresent} = {r.lb, r.acq, r.fp};
		lipDone = 1'b1;
		tick;
		lipDone = 1'b0;
		if (r.fan == 2'h0 && r.fp) begin
			probe(F_PLOGI, A_REJECT);
			rxValid = 1'b0;
		end
		if (r.fan != 2'h0) begin
			probe(F_ADISC, A_REJECT);
			probe(F_OTHER, A_DISCARD);
			rxValid = r.fan != 2'h3;
			rxKind = F_FAN;
			fanMatch = r.fan == 2'h1;
			tick;
			rxValid = 1'b0;
		end
		if (r.eDrop) begin
			for (i = 0; i < 60 && nD == 0; i++) tick;
			probe(F_PLOGI, A_REJECT);
			probe(F_ADISC, A_SEND_LOGO);
			probe(F_OTHER, A_DISCARD);
			probe(F_LOGO_ACC, A_PASS);
			rxValid = 1'b0;
		end
		for (i = 0; i < 600 && initDone !== 1'b1 && privateMode !== 1'b1; i++)
			tick;
		tick;
		check("login", nF != 0, r.eLogin);
		check("drop", nD != 0, r.eDrop);
		check("directory", nN != 0, r.eNs);
		check("resume", nR != 0, r.eRes);
		check("privateMode", privateMode, r.ePriv);
		check("finished", initDone | privateMode, 1'b1);
		check("logout", nL != 0, r.eLogin && r.fan != 2'h3);
		check("privateAuth", nA != 0, r.eRes);
	endtask

	task automatic test_done;
		$display("Comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Watchdog well beyond the expected few hundred cycles
	initial begin
		#200000;
		error_cnt++;
		test_done;
	end

	initial begin
		{clk, lipStart, lipDone, lispLBit, alpaAcquired, flPortPresent} = '0;
		{rxValid, fanMatch, okCfg, chgCfg, slow} = '0;
		alpaNow = 8'h2a;
		rxKind = F_OTHER;
		sys_rst = 1'b1;
		repeat (2) tick;
		sys_rst = 1'b0;
		check("reqDestId", reqDestId, 24'hfffffe);
		check("initDone", initDone, 1'b0);
		foreach (rows[i]) run_row(rows[i]);
		// Log in afresh after the private rows, restoring the held address and login
		run_row(rows[0]);
		// A new address from the loop forces recovery and registration
		alpaNow = 8'h3c;
		run_row(addrMoved);
		lipStart = 1'b1;
		tick;
		lipStart = 1'b0;
		lipDone = 1'b1;
		tick;
		lipDone = 1'b0;
		repeat (5) tick;
		sys_rst = 1'b1;
		tick;
		check("flogiReq", flogiReq, 1'b0);
		check("initDone", initDone, 1'b0);
		sys_rst = 1'b0;
		tick;
		check("reqDestId", reqDestId, 24'hfffffe);
		// Login state is lost with reset, so the next LIP starts afresh
		run_row(rows[0]);
		test_done;
	end
endmodule

/* File: tov_timer.sv */
`timescale 1ns/10ps
`include "loop_port_defs.svh"

// Loadable down-counter for fabric-supplied timeouts, one tick per enable
module tov_timer #(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             sys_rst,
	// Control
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] loadValue,
	input  wire logic             tick,
	// Status
	output logic                  expired,
	output logic                  running
);

	initial begin
		if (WIDTH < 2) $error("tov_timer WIDTH too small");
	end

	logic [WIDTH-1:0] count;

	// Zero count while running means expiry
	assign expired = running && (count == '0);

	// Count down on each enable pulse; a load restarts the wait
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count   <= '0;
			running <= 1'b0;
		end else if (load) begin
			count   <= loadValue;
			running <= 1'b1;
		end else if (expired) begin
			running <= 1'b0;
		end else if (running && tick) begin
			count   <= count - 1'b1;
		end
	end

endmodule
